// ### ssp_baud_gen.sv
// reloadable baud tick generator, counts only while running
`timescale 1ns/100ps
`default_nettype none
module ssp_baud_gen #(
   parameter int unsigned W = 16
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // control
   input wire logic run_in,
   input wire logic [W-1:0] reload_in,
   // tick
   output logic tick_out
);
   ssp_pkg::ssp_baud_state_t s_r;
   ssp_pkg::ssp_baud_state_t s_nxt;

   // width check
   if (W < 2 || W > 16) begin : g_bad_w
      $error("ssp_baud_gen: W must be 2..16");
   end

   // reload when stopped, tick every reload+1 cycles when running
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (!run_in) begin
         s_nxt.cnt = 16'(reload_in);
      end else if (s_r.cnt == 16'h0000) begin
         s_nxt.tick = 1'b1; // zero reload ticks every cycle
         s_nxt.cnt = 16'(reload_in);
      end else begin
         s_nxt.cnt = s_r.cnt - 16'h0001;
      end
   end

   // state register
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick_out = s_r.tick;
endmodule // ssp_baud_gen
`default_nettype wire

// ### ssp_pkg.sv
// shared constants and types of the synchronous serial port
package ssp_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TXB = 8'h04;
   localparam logic [7:0] OFS_RXB = 8'h08;
   localparam logic [7:0] OFS_BAUD = 8'h0C;
   // control view fields (channel disabled)
   localparam int unsigned CTL_BITS_LSB = 0;
   localparam int unsigned CTL_MSB_FIRST = 4;
   localparam int unsigned CTL_PHASE = 5;
   localparam int unsigned CTL_POLARITY = 6;
   localparam int unsigned CTL_MASTER = 14;
   localparam int unsigned CTL_ENABLE = 15;
   // status view fields (channel enabled)
   localparam int unsigned STS_TX_ERR = 8;
   localparam int unsigned STS_RX_ERR = 9;
   localparam int unsigned STS_PH_ERR = 10;
   localparam int unsigned STS_BR_ERR = 11;
   localparam int unsigned STS_BUSY = 12;
   // values after reset
   localparam logic [3:0] BITS_M1_RST = 4'h7;
   localparam logic [15:0] BAUD_RST = 16'h0000;
   // slave clock half period limit, least time rounded up
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned SLAVE_MIN_HALF_PS = 60606;
   localparam int unsigned SLAVE_MIN_HALF_CYC =
      (SLAVE_MIN_HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [4:0] GAP_MIN = 5'(SLAVE_MIN_HALF_CYC);

   // transfer states
   typedef enum logic [1:0] {
      SSP_IDLE = 2'b01,
      SSP_RUN = 2'b10
   } ssp_state_e_t;

   // configuration bits
   typedef struct packed {
      logic enable;
      logic master;
      logic polarity;
      logic phase;
      logic msb_first;
      logic [3:0] bits_m1;
   } ssp_cfg_t;

   // error flags
   typedef struct packed {
      logic baud;
      logic phase;
      logic rx;
      logic tx;
   } ssp_err_t;

   // whole state of the port
   typedef struct packed {
      ssp_cfg_t cfg;
      ssp_err_t err;
      ssp_state_e_t st;
      logic [15:0] baud;
      logic [15:0] txb;
      logic tx_full;
      logic [15:0] rxb;
      logic rx_full;
      logic [15:0] sr;
      logic [4:0] k;
      logic started;
      logic busy;
      logic dout;
      logic sclk;
      logic sclk_q;
      logic din_q;
      logic [4:0] gap;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic tx_irq;
      logic rx_irq;
      logic err_irq;
   } ssp_state_t;

   // baud generator state
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } ssp_baud_state_t;
endpackage

// ### ssp_port.sv
// synchronous serial master/slave port with apb registers
// Function
// - frame length programmable from 2 to 16 bits, tx and rx equal
// - shift-order bit 1 sends msb first, 0 sends lsb first
// - buffer data right aligned, frame lsb at bit 0
// - polarity bit sets clock idle level; idle high means falling leading edge
// - shift out on one edge, latch on the other; phase bit picks which
// - one shift register sends and receives together, bit for bit
// - holding buffer word moves to shift register once it is empty
// - master starts at once after load, slave waits for external clock
// - transfer start sets busy and pulses transmit request
// - frame end copies shift register to receive buffer, pulses receive request
// - busy clears with receive buffer load when no word is waiting
// - control register shows configuration when disabled, status when enabled
// - 16-bit baud counter runs only during a transfer
// - zero baud reload is a valid master setting
// - master shift clock divided by two for even duty cycle
// - requests for tx empty, rx full and rx, phase, baud, tx errors
// - master makes the shift clock, slave takes it from outside
// - slave drives first bit at load, master waits for next tick
// - data output keeps last bit; disabled outputs stay high
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module ssp_port (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // shift clock pin
   input wire logic shift_clock_pin_in,
   output logic shift_clock_pin_out,
   output logic shift_clock_pin_oe_out,
   // master data out / slave data in pin
   input wire logic master_out_slave_in_pin_in,
   output logic master_out_slave_in_pin_out,
   output logic master_out_slave_in_pin_oe_out,
   // master data in / slave data out pin
   input wire logic master_in_slave_out_pin_in,
   output logic master_in_slave_out_pin_out,
   output logic master_in_slave_out_pin_oe_out,
   // request lines
   output logic transmit_irq_request_out,
   output logic receive_irq_request_out,
   output logic error_irq_request_out
);
   ssp_pkg::ssp_state_t s_r;
   ssp_pkg::ssp_state_t s_nxt;
   logic rst_meta_r;
   logic rst_n_r;
   logic tick;
   logic baud_run;
   logic wr;
   logic rd;
   logic mapped;
   logic [4:0] nbits;
   logic [4:0] last_k;
   logic rx_pin;
   logic sclk_s;
   logic sedge;
   logic ev;
   logic latch;
   logic last;
   logic [15:0] shifted;
   logic [15:0] ctrl_view;

   // output bit of a word for the chosen order
   function automatic logic f_outbit(input logic [15:0] w, input logic msb,
                                     input logic [4:0] nb);
      f_outbit = msb ? w[4'(nb - 5'd1)] : w[0];
   endfunction

   // one shift step, received bit enters at the far end
   function automatic logic [15:0] f_shift(input logic [15:0] w, input logic msb,
                                           input logic [4:0] nb, input logic b);
      logic [15:0] t;
      t = msb ? {w[14:0], b} : {1'b0, w[15:1]};
      if (!msb) begin
         t[4'(nb - 5'd1)] = b; // right aligned result
      end
      f_shift = t;
   endfunction

   // reset release through two flip-flops
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // baud tick generator, runs only in a master transfer
   assign baud_run = s_r.cfg.enable && s_r.cfg.master && (s_r.st == ssp_pkg::SSP_RUN);
   ssp_baud_gen #(
      .W(16)
   ) u_baud (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_r),
      .run_in(baud_run),
      .reload_in(s_r.baud),
      .tick_out(tick)
   );

   // frame length and bus decode
   assign nbits = (s_r.cfg.bits_m1 == 4'h0) ? 5'd2 : 5'(s_r.cfg.bits_m1) + 5'd1;
   assign last_k = 5'((nbits << 1) - 5'd1);
   assign wr = psel_in && penable_in && pwrite_in;
   assign rd = psel_in && penable_in && !pwrite_in;
   assign mapped = (paddr_in == ssp_pkg::OFS_CTRL) || (paddr_in == ssp_pkg::OFS_TXB) ||
                   (paddr_in == ssp_pkg::OFS_RXB) || (paddr_in == ssp_pkg::OFS_BAUD);
   // synchronised pins
   assign sclk_s = s_r.sync2[2];
   assign rx_pin = s_r.cfg.master ? s_r.sync2[0] : s_r.sync2[1];
   assign sedge = s_r.cfg.enable && !s_r.cfg.master && (sclk_s != s_r.sclk_q);
   // one edge of the shift clock, generated or received
   assign ev = s_r.cfg.master ? (tick && s_r.started && s_r.st == ssp_pkg::SSP_RUN) :
               (sedge && (s_r.st == ssp_pkg::SSP_RUN || !s_r.tx_full));
   assign latch = ~s_r.k[0] ^ s_r.cfg.phase;
   assign last = (s_r.k == last_k);
   assign shifted = f_shift(s_r.sr, s_r.cfg.msb_first, nbits, rx_pin);

   // next-state logic
   always_comb begin
      s_nxt = s_r;
      s_nxt.tx_irq = 1'b0;
      s_nxt.rx_irq = 1'b0;
      s_nxt.err_irq = 1'b0;
      s_nxt.sync1 = {shift_clock_pin_in, master_out_slave_in_pin_in, master_in_slave_out_pin_in};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sclk_q = sclk_s;
      s_nxt.din_q = rx_pin;
      s_nxt.gap = (s_r.gap == 5'h1F) ? s_r.gap : s_r.gap + 5'd1;
      // reads and control writes clear before hardware sets
      if (rd && paddr_in == ssp_pkg::OFS_RXB) begin
         s_nxt.rx_full = 1'b0;
      end
      if (wr && paddr_in == ssp_pkg::OFS_CTRL) begin
         if (!s_r.cfg.enable) begin
            s_nxt.cfg.bits_m1 = pwdata_in[ssp_pkg::CTL_BITS_LSB +: 4];
            s_nxt.cfg.msb_first = pwdata_in[ssp_pkg::CTL_MSB_FIRST];
            s_nxt.cfg.phase = pwdata_in[ssp_pkg::CTL_PHASE];
            s_nxt.cfg.polarity = pwdata_in[ssp_pkg::CTL_POLARITY];
         end else begin
            // status view: writing zero clears an error flag
            s_nxt.err.tx = s_r.err.tx & pwdata_in[ssp_pkg::STS_TX_ERR];
            s_nxt.err.rx = s_r.err.rx & pwdata_in[ssp_pkg::STS_RX_ERR];
            s_nxt.err.phase = s_r.err.phase & pwdata_in[ssp_pkg::STS_PH_ERR];
            s_nxt.err.baud = s_r.err.baud & pwdata_in[ssp_pkg::STS_BR_ERR];
         end
         s_nxt.cfg.master = pwdata_in[ssp_pkg::CTL_MASTER];
         s_nxt.cfg.enable = pwdata_in[ssp_pkg::CTL_ENABLE];
      end
      if (wr && paddr_in == ssp_pkg::OFS_BAUD) begin
         s_nxt.baud = pwdata_in[15:0];
      end
      // transfer engine
      if (!s_r.cfg.enable) begin
         s_nxt.st = ssp_pkg::SSP_IDLE;
         s_nxt.busy = 1'b0;
         s_nxt.dout = 1'b1;
         s_nxt.sclk = s_r.cfg.polarity;
      end else begin
         // load an idle shift register from the holding buffer
         if (s_r.st == ssp_pkg::SSP_IDLE && s_r.tx_full) begin
            s_nxt.sr = s_r.txb;
            s_nxt.tx_full = 1'b0;
            s_nxt.st = ssp_pkg::SSP_RUN;
            s_nxt.busy = 1'b1;
            s_nxt.tx_irq = 1'b1;
            s_nxt.k = 5'd0;
            s_nxt.started = !s_r.cfg.master;
            s_nxt.sclk = s_r.cfg.polarity;
            if (!s_r.cfg.master) begin
               s_nxt.dout = f_outbit(s_r.txb, s_r.cfg.msb_first, nbits);
            end
         end else if (s_r.st == ssp_pkg::SSP_IDLE) begin
            s_nxt.sclk = s_r.cfg.polarity;
         end
         // master: first tick only places the first bit
         if (s_r.cfg.master && tick && !s_r.started) begin
            s_nxt.dout = f_outbit(s_r.sr, s_r.cfg.msb_first, nbits);
            s_nxt.started = 1'b1;
         end
         // slave clocked with nothing loaded: old contents go out
         if (!s_r.cfg.master && ev && s_r.st == ssp_pkg::SSP_IDLE) begin
            s_nxt.err.tx = 1'b1;
            s_nxt.err_irq = 1'b1;
            s_nxt.st = ssp_pkg::SSP_RUN;
            s_nxt.busy = 1'b1;
            s_nxt.k = 5'd0;
         end
         // slave edges closer than the allowed half period
         if (sedge) begin
            s_nxt.gap = 5'd0;
            if (s_r.gap < ssp_pkg::GAP_MIN - 5'd1) begin
               s_nxt.err.baud = 1'b1;
               s_nxt.err_irq = 1'b1;
            end
         end
         if (ev) begin
            if (s_r.cfg.master) begin
               s_nxt.sclk = ~s_r.sclk; // one toggle per tick
            end
            s_nxt.k = s_r.k + 5'd1;
            if (latch) begin
               s_nxt.sr = shifted;
               if (!s_r.cfg.master && rx_pin != s_r.din_q) begin
                  s_nxt.err.phase = 1'b1;
                  s_nxt.err_irq = 1'b1;
               end
            end else if (!last) begin
               s_nxt.dout = f_outbit(s_r.sr, s_r.cfg.msb_first, nbits);
            end
            if (last) begin
               // phase 0 ends on a shift edge: the word is already complete
               s_nxt.rxb = latch ? shifted : s_r.sr;
               s_nxt.rx_irq = 1'b1;
               if (s_r.rx_full && !(rd && paddr_in == ssp_pkg::OFS_RXB)) begin
                  s_nxt.err.rx = 1'b1;
                  s_nxt.err_irq = 1'b1;
               end
               s_nxt.rx_full = 1'b1;
               if (s_r.tx_full) begin
                  s_nxt.sr = s_r.txb; // back to back
                  s_nxt.tx_full = 1'b0;
                  s_nxt.tx_irq = 1'b1;
                  s_nxt.k = 5'd0;
                  s_nxt.started = !s_r.cfg.master;
                  if (!s_r.cfg.master) begin
                     s_nxt.dout = f_outbit(s_r.txb, s_r.cfg.msb_first, nbits);
                  end
               end else begin
                  s_nxt.busy = 1'b0;
                  s_nxt.st = ssp_pkg::SSP_IDLE;
               end
            end
         end
      end
      // holding buffer write wins over a load in the same cycle
      if (wr && paddr_in == ssp_pkg::OFS_TXB) begin
         s_nxt.txb = pwdata_in[15:0];
         s_nxt.tx_full = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         s_r <= '0;
         s_r.st <= ssp_pkg::SSP_IDLE;
         s_r.cfg.bits_m1 <= ssp_pkg::BITS_M1_RST;
         s_r.baud <= ssp_pkg::BAUD_RST;
         s_r.dout <= 1'b1;
         s_r.sclk <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // control register read view, busy has no write path
   always_comb begin
      ctrl_view = 16'h0000;
      ctrl_view[ssp_pkg::CTL_MASTER] = s_r.cfg.master;
      ctrl_view[ssp_pkg::CTL_ENABLE] = s_r.cfg.enable;
      if (s_r.cfg.enable) begin
         ctrl_view[ssp_pkg::CTL_BITS_LSB +: 4] = s_r.k[4:1];
         ctrl_view[ssp_pkg::STS_TX_ERR] = s_r.err.tx;
         ctrl_view[ssp_pkg::STS_RX_ERR] = s_r.err.rx;
         ctrl_view[ssp_pkg::STS_PH_ERR] = s_r.err.phase;
         ctrl_view[ssp_pkg::STS_BR_ERR] = s_r.err.baud;
         ctrl_view[ssp_pkg::STS_BUSY] = s_r.busy;
      end else begin
         ctrl_view[ssp_pkg::CTL_BITS_LSB +: 4] = s_r.cfg.bits_m1;
         ctrl_view[ssp_pkg::CTL_MSB_FIRST] = s_r.cfg.msb_first;
         ctrl_view[ssp_pkg::CTL_PHASE] = s_r.cfg.phase;
         ctrl_view[ssp_pkg::CTL_POLARITY] = s_r.cfg.polarity;
      end
   end

   // apb read mux, zero wait states
   always_comb begin
      prdata_out = 32'h0000_0000;
      if (rd) begin
         case (paddr_in)
            ssp_pkg::OFS_CTRL: prdata_out = {16'h0000, ctrl_view};
            ssp_pkg::OFS_TXB: prdata_out = {16'h0000, s_r.txb};
            ssp_pkg::OFS_RXB: prdata_out = {16'h0000, s_r.rxb};
            ssp_pkg::OFS_BAUD: prdata_out = {16'h0000, s_r.baud};
            default: prdata_out = 32'h0000_0000;
         endcase
      end
   end
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;

   // pins: master drives clock and data out, slave drives its data out
   assign shift_clock_pin_out = s_r.cfg.enable ? s_r.sclk : 1'b1;
   assign shift_clock_pin_oe_out = s_r.cfg.enable && s_r.cfg.master;
   assign master_out_slave_in_pin_out = s_r.dout;
   assign master_out_slave_in_pin_oe_out = s_r.cfg.enable && s_r.cfg.master;
   assign master_in_slave_out_pin_out = s_r.dout;
   assign master_in_slave_out_pin_oe_out = s_r.cfg.enable && !s_r.cfg.master;
   // request pulses
   assign transmit_irq_request_out = s_r.tx_irq;
   assign receive_irq_request_out = s_r.rx_irq;
   assign error_irq_request_out = s_r.err_irq;
endmodule // ssp_port
`default_nettype wire

// ### ssp_port_chk.sv
// assertion checker for the serial port pins and requests
`timescale 1ns/100ps
`default_nettype none
module ssp_port_chk (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // pins
   input wire logic shift_clock_pin_out,
   input wire logic shift_clock_pin_oe_out,
   input wire logic master_out_slave_in_pin_out,
   input wire logic master_out_slave_in_pin_oe_out,
   input wire logic master_in_slave_out_pin_out,
   input wire logic master_in_slave_out_pin_oe_out,
   // requests
   input wire logic transmit_irq_request_out,
   input wire logic receive_irq_request_out
);
   default clocking cb_chk @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   wire logic ck = shift_clock_pin_out;
   wire logic ckoe = shift_clock_pin_oe_out;
   wire logic txr = transmit_irq_request_out;
   wire logic rxr = receive_irq_request_out;
   logic sclk_d;
   logic [5:0] cnt;
   logic [5:0] tot;
   // shift clock edges since the last load
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sclk_d <= 1'b1;
         cnt <= 6'h00;
      end else begin
         sclk_d <= ck;
         cnt <= txr ? 6'h00 : tot;
      end
   end
   assign tot = cnt + 6'(ck != sclk_d);

   property p_pin_dir;
      !(ckoe && master_in_slave_out_pin_oe_out) && ckoe == master_out_slave_in_pin_oe_out;
   endproperty
   a_pin_dir: assert property (p_pin_dir)
      else $error("pin enables mixed");
   property p_tx_pulse;
      txr |=> !txr;
   endproperty
   a_tx_pulse: assert property (p_tx_pulse)
      else $error("transmit request too long");
   property p_rx_pulse;
      rxr |=> !rxr;
   endproperty
   a_rx_pulse: assert property (p_rx_pulse)
      else $error("receive request too long");
   property p_first_quiet;
      txr && ckoe && !rxr |-> $stable(ck);
   endproperty
   a_first_quiet: assert property (p_first_quiet)
      else $error("clock moved at load");
   property p_off_high;
      (!ckoe && !master_in_slave_out_pin_oe_out)[*3] |->
         ck && master_out_slave_in_pin_out && master_in_slave_out_pin_out;
   endproperty
   a_off_high: assert property (p_off_high)
      else $error("disabled outputs not high");
   property p_frame_len;
      txr && ckoe |-> ##[4:1000] rxr;
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("frame never completed");
   property p_edges;
      rxr && ckoe |-> !tot[0] && tot >= 6'h04 && tot <= 6'h20;
   endproperty
   a_edges: assert property (p_edges)
      else $error("bad clock edge count");
   property p_hold;
      rxr && !txr && ckoe |=> ($stable(ck) && $stable(master_out_slave_in_pin_out))[*3];
   endproperty
   a_hold: assert property (p_hold)
      else $error("lines moved after frame");
endmodule // ssp_port_chk

bind ssp_port ssp_port_chk u_chk (
   .clk_sys_in(clk_sys_in),
   .rst_n_in(rst_n_in),
   .shift_clock_pin_out(shift_clock_pin_out),
   .shift_clock_pin_oe_out(shift_clock_pin_oe_out),
   .master_out_slave_in_pin_out(master_out_slave_in_pin_out),
   .master_out_slave_in_pin_oe_out(master_out_slave_in_pin_oe_out),
   .master_in_slave_out_pin_out(master_in_slave_out_pin_out),
   .master_in_slave_out_pin_oe_out(master_in_slave_out_pin_oe_out),
   .transmit_irq_request_out(transmit_irq_request_out),
   .receive_irq_request_out(receive_irq_request_out)
);
`default_nettype wire

// ### ssp_port_tb.sv
// self-checking bench for the serial port in master mode, plus one slave first-bit test
`timescale 1ns/100ps
`default_nettype none
module ssp_port_tb;
   typedef struct packed {
      logic [3:0] bm1;
      logic msb;
      logic ph;
      logic pol;
      logic [15:0] baud;
      logic [15:0] tx;
      logic [15:0] peer;
      logic chk;
   } ssp_row_t;
   ssp_row_t rows [5] = '{
      '{4'h7, 1'b0, 1'b0, 1'b0, 16'h0003, 16'hFFA5, 16'h003C, 1'b1},
      '{4'hF, 1'b1, 1'b1, 1'b0, 16'h0002, 16'hC3A1, 16'h5E71, 1'b1},
      '{4'h1, 1'b1, 1'b0, 1'b1, 16'h0002, 16'h0002, 16'h0001, 1'b1},
      '{4'h4, 1'b0, 1'b1, 1'b1, 16'h0003, 16'h0013, 16'h000A, 1'b1},
      '{4'hB, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0B5C, 16'h0A63, 1'b0}};
   ssp_row_t cur;
   logic clk_sys_in, rst_n_in, psel, penable, pwrite, ev, sel;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv, cfg, m;
   logic pready, pslverr, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
   logic tx_irq, rx_irq, err_irq;
   logic [15:0] peer_rx;
   int mismatches, checked, ntx, nrx, nerr;
   // pin levels, pulled high when nobody drives
   wire logic sclk_w = sclk_oe ? sclk_o : 1'b1;
   wire logic mosi_w = mosi_oe ? mosi_o : 1'b1;
   wire logic peer_miso;
   wire logic miso_w = miso_oe ? miso_o : peer_miso;
   ssp_port DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .shift_clock_pin_in(sclk_w), .shift_clock_pin_out(sclk_o),
      .shift_clock_pin_oe_out(sclk_oe), .master_out_slave_in_pin_in(mosi_w),
      .master_out_slave_in_pin_out(mosi_o), .master_out_slave_in_pin_oe_out(mosi_oe),
      .master_in_slave_out_pin_in(miso_w), .master_in_slave_out_pin_out(miso_o),
      .master_in_slave_out_pin_oe_out(miso_oe), .transmit_irq_request_out(tx_irq),
      .receive_irq_request_out(rx_irq), .error_irq_request_out(err_irq));
   ssp_spi_peer u_peer (.sclk_in(sclk_w), .mosi_in(mosi_w), .miso_out(peer_miso),
      .sel_in(sel), .cpol_in(cur.pol), .cpha_in(cur.ph), .msb_in(cur.msb),
      .n_in(5'(cur.bm1) + 5'h01), .word_in(cur.peer), .rx_out(peer_rx));
   // clock
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   // request pulse counters
   always @(posedge clk_sys_in) begin
      if (tx_irq === 1'b1) ntx++;
      if (rx_irq === 1'b1) nrx++;
      if (err_irq === 1'b1) nerr++;
   end
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   // one apb transfer, setup then access until ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys_in);
      end while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // configure master, check both control views, select the peer
   task automatic setup();
      cfg = {16'h0000, 2'b01, 7'h00, cur.pol, cur.ph, cur.msb, cur.bm1};
      m = 32'h0000FFFF >> (5'h0F - 5'(cur.bm1));
      apb(1'b1, ssp_pkg::OFS_CTRL, cfg);
      apb(1'b0, ssp_pkg::OFS_CTRL, 32'h0);
      chk(rv, cfg, "config view");
      apb(1'b1, ssp_pkg::OFS_BAUD, {16'h0000, cur.baud});
      apb(1'b1, ssp_pkg::OFS_CTRL, cfg | 32'h00008000);
      apb(1'b0, ssp_pkg::OFS_CTRL, 32'h0);
      chk(rv & 32'hFFF0, 32'h0000C000, "status view");
      sel = 1'b1;
   endtask
   // wait for busy to drop, then check words and request counts
   task automatic finish(input int k, input int ke, input int t0, input int r0, input int e0);
      int n;
      n = 0;
      repeat (6) @(posedge clk_sys_in);
      do begin
         apb(1'b0, ssp_pkg::OFS_CTRL, 32'h0);
         n++;
      end while (rv[ssp_pkg::STS_BUSY] !== 1'b0 && n < 300);
      chk(32'(n < 300), 32'h1, "busy stuck");
      chk(32'(rv[ssp_pkg::STS_RX_ERR]), 32'(ke), "rx error flag");
      apb(1'b0, ssp_pkg::OFS_RXB, 32'h0);
      if (cur.chk) chk(rv & m, {16'h0000, cur.peer} & m, "rx word");
      chk({16'h0000, peer_rx} & m, {16'h0000, cur.tx} & m, "peer word");
      chk(32'(ntx - t0), 32'(k), "tx requests");
      chk(32'(nrx - r0), 32'(k), "rx requests");
      chk(32'(nerr - e0), 32'(ke), "error requests");
      sel = 1'b0;
   endtask
   initial begin
      #200000;
      mismatches++;
      give_verdict();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, sel} = '0;
      {mismatches, checked, ntx, nrx, nerr} = '0;
      rst_n_in = 1'b0;
      cur = rows[0];
      repeat (3) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      apb(1'b0, ssp_pkg::OFS_CTRL, 32'h0);
      chk(rv, {28'h0000000, ssp_pkg::BITS_M1_RST}, "ctrl reset");
      apb(1'b0, ssp_pkg::OFS_BAUD, 32'h0);
      chk(rv, {16'h0000, ssp_pkg::BAUD_RST}, "baud reset");
      apb(1'b0, 8'h10, 32'h0);
      chk({rv[30:0], ev}, 32'h1, "unmapped");
      $display("test reset done");
      // table of single frames over lengths, orders, phases, polarities, rates
      foreach (rows[i]) begin
         cur = rows[i];
         setup();
         fork
            apb(1'b1, ssp_pkg::OFS_TXB, {16'hFFFF, cur.tx});
            finish(1, 0, ntx, nrx, nerr);
         join
         apb(1'b1, ssp_pkg::OFS_CTRL, 32'h0);
         $display("test row %0d done", i);
      end
      // back to back frames, second overwrites unread word, busy write refused
      cur = '{4'h7, 1'b1, 1'b0, 1'b0, 16'h0003, 16'h0096, 16'h0069, 1'b1};
      setup();
      fork
         begin
            apb(1'b1, ssp_pkg::OFS_TXB, {16'h0000, ~cur.tx});
            apb(1'b1, ssp_pkg::OFS_TXB, {16'h0000, cur.tx});
         end
         finish(2, 1, ntx, nrx, nerr);
      join
      apb(1'b1, ssp_pkg::OFS_CTRL, 32'h0000D000);
      apb(1'b0, ssp_pkg::OFS_CTRL, 32'h0);
      chk(rv & 32'hFFF0, 32'h0000C000, "busy write");
      apb(1'b1, ssp_pkg::OFS_CTRL, 32'h0);
      $display("test back to back done");
      // slave drives its first bit as soon as the word is loaded
      apb(1'b1, ssp_pkg::OFS_CTRL, 32'h00000017);
      apb(1'b1, ssp_pkg::OFS_CTRL, 32'h00008017);
      apb(1'b1, ssp_pkg::OFS_TXB, 32'h0000007F);
      repeat (2) @(posedge clk_sys_in);
      chk({30'h0, miso_oe, miso_o}, 32'h00000002, "slave first bit");
      apb(1'b0, ssp_pkg::OFS_CTRL, 32'h0);
      chk(rv & 32'hFFF0, 32'h00009000, "slave busy");
      apb(1'b1, ssp_pkg::OFS_CTRL, 32'h0);
      $display("test slave done");
      give_verdict();
   end
endmodule // ssp_port_tb
`default_nettype wire

// ### ssp_spi_peer.sv
// behavioural spi slave facing the port in master mode
`timescale 1ns/100ps
`default_nettype none
module ssp_spi_peer (
   // pins
   input wire logic sclk_in,
   input wire logic mosi_in,
   output logic miso_out,
   // frame setup
   input wire logic sel_in,
   input wire logic cpol_in,
   input wire logic cpha_in,
   input wire logic msb_in,
   input wire logic [4:0] n_in,
   input wire logic [15:0] word_in,
   // result
   output logic [15:0] rx_out
);
   int ti;
   int ri;
   logic [15:0] acc;
   // word position of frame bit i
   function automatic int pos(input int i);
      return msb_in ? int'(n_in) - 1 - i : i;
   endfunction
   // put the next word bit on the line
   task automatic drive();
      miso_out = word_in[pos(ti)];
      ti++;
   endtask
   initial begin
      miso_out = 1'b1;
      ti = 0;
      ri = 0;
      acc = 16'h0000;
      rx_out = 16'h0000;
   end
   // selection loads the word; phase 0 needs the first bit at once
   always @(sel_in) begin
      ti = 0;
      ri = 0;
      if (sel_in && !cpha_in) drive();
   end
   // deselected line shows a changing filler
   always #7 if (!sel_in) miso_out = ~miso_out;
   // clock only sensed, never driven: one master per bus
   always @(sclk_in) if (sel_in) begin
      if ((sclk_in != cpol_in) != cpha_in) begin
         acc[pos(ri)] = mosi_in;
         ri++;
         if (ri == int'(n_in)) begin
            rx_out = acc;
            ri = 0;
            ti = 0;
         end
      end else drive();
   end
endmodule // ssp_spi_peer
`default_nettype wire
